// ### test_usb_error_status_control_regs.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module test_usb_error_status_control_regs;
   // -------------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------------
   logic                    core_clk, arst_n, err_irq_master_en;
   usb_regs_pkg::bus_req_s  bus_req;
   logic [31:0]             rdata;
   logic [7:0]              err_flags;
   usb_regs_pkg::xfer_rec_s xfer_rec;
   usb_regs_pkg::xfer_rec_s recs [5];
   logic                    err_irq, module_irq_req, xfer_done, xfer_ready, transaction_done_flag;
   logic                    setup_token_seen, token_active, dp_pin, dm_pin, token_hold;
   logic                    bus_reset_drive, host_role_enable, host_logic_reset, resume_drive;
   logic                    ls_eop_drive, pingpong_pointer_clear, module_enable, sof_strobe;
   int                      n_fail, n_checks, n_sof, n_eop, n_hrst, cycles;

   usb_error_status_control_regs dut
   (
      .core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
      .err_flags(err_flags), .err_irq_master_en(err_irq_master_en), .err_irq(err_irq),
      .module_irq_req(module_irq_req), .xfer_done(xfer_done), .xfer_rec(xfer_rec),
      .xfer_ready(xfer_ready), .transaction_done_flag(transaction_done_flag),
      .setup_token_seen(setup_token_seen), .token_active(token_active), .dp_pin(dp_pin),
      .dm_pin(dm_pin), .token_hold(token_hold), .bus_reset_drive(bus_reset_drive),
      .host_role_enable(host_role_enable), .host_logic_reset(host_logic_reset),
      .resume_drive(resume_drive), .ls_eop_drive(ls_eop_drive),
      .pingpong_pointer_clear(pingpong_pointer_clear), .module_enable(module_enable),
      .sof_strobe(sof_strobe)
   );

   usb_far_side_model far
   (
      .core_clk(core_clk), .xfer_ready(xfer_ready), .xfer_done(xfer_done),
      .xfer_rec(xfer_rec), .setup_token_seen(setup_token_seen),
      .token_active(token_active), .dp_pin(dp_pin), .dm_pin(dm_pin)
   );

   // -------------------------------------------------------------------------
   // Clock, event counters and hang guard
   // -------------------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Ceiling sits above one full frame wait plus the short tests
   always @(posedge core_clk)
   begin
      cycles++;
      if (sof_strobe === 1'b1) n_sof++;
      if (ls_eop_drive === 1'b1) n_eop++;
      if (host_logic_reset === 1'b1) n_hrst++;
      if (cycles == 102000)
      begin
         n_fail++;
         test_done();
      end
   end

   // -------------------------------------------------------------------------
   // Register bus tasks
   // -------------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_req <= {a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      bus_req <= {a, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask

   task automatic test_done();
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial
   begin
      arst_n = 1'b0;
      bus_req = '0;
      err_flags = 8'h00;
      err_irq_master_en = 1'b0;
      recs = '{6'h02, 6'h3d, 6'h17, 6'h28, 6'h26};
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      rchk(usb_regs_pkg::OFF_ERR_EN, 32'h0);
      rchk(usb_regs_pkg::OFF_STATUS, 32'h0);
      rchk(usb_regs_pkg::OFF_CTRL, 32'h80);
      // Live line flags follow the bus after the synchroniser delay
      far.set_line(1'b0, 1'b0);
      repeat (6) @(posedge core_clk);
      rchk(usb_regs_pkg::OFF_CTRL, 32'h40);
      far.set_line(1'b0, 1'b1);
      repeat (6) @(posedge core_clk);
      rchk(usb_regs_pkg::OFF_CTRL, 32'h00);
      far.set_line(1'b1, 1'b0);
      // Upper bits never stick; unmapped place reads zero and leaves others alone
      wr(usb_regs_pkg::OFF_ERR_EN, 32'hffff_ff5a);
      wr(8'h10, 32'hffff_ffff);
      rchk(8'h10, 32'h0);
      rchk(usb_regs_pkg::OFF_ERR_EN, 32'h5a);
      // Each flag alone: blocked by all other enables, passed by its own
      for (int i = 0; i < 8; i++)
      begin
         err_flags <= 8'h01 << i;
         err_irq_master_en <= i[0];
         wr(usb_regs_pkg::OFF_ERR_EN, {24'h0, ~(8'h01 << i)});
         `CHK(err_irq, 1'b0)
         `CHK(module_irq_req, 1'b0)
         wr(usb_regs_pkg::OFF_ERR_EN, {24'h0, 8'h01 << i});
         `CHK(err_irq, 1'b1)
         `CHK(module_irq_req, i[0])
      end
      err_flags <= 8'h00;
      // Queue: fill four, fifth stalls, then drain in order
      rchk(usb_regs_pkg::OFF_MISC, 32'h2);
      for (int k = 0; k < 4; k++) far.complete(recs[k]);
      #1;
      `CHK(xfer_ready, 1'b0)
      fork
         far.complete(recs[4]);
      join_none
      repeat (3) @(posedge core_clk);
      `CHK(transaction_done_flag, 1'b1)
      for (int k = 0; k < 5; k++)
      begin
         rchk(usb_regs_pkg::OFF_STATUS, {24'h0, recs[k], 2'b00});
         wr(usb_regs_pkg::OFF_MISC, 32'h1);
      end
      rchk(usb_regs_pkg::OFF_MISC, 32'h2);
      `CHK(transaction_done_flag, 1'b0)
      // Peripheral role: enable, SETUP hold and its software clear
      wr(usb_regs_pkg::OFF_CTRL, 32'h01);
      `CHK(module_enable, 1'b1)
      far.setup_pulse();
      rchk(usb_regs_pkg::OFF_CTRL, 32'ha1);
      `CHK(token_hold, 1'b1)
      wr(usb_regs_pkg::OFF_CTRL, 32'h01);
      `CHK(token_hold, 1'b0)
      wr(usb_regs_pkg::OFF_CTRL, 32'h11);
      `CHK(bus_reset_drive, 1'b0)
      // Host role: token busy, bus reset, resume and its closing EOP
      wr(usb_regs_pkg::OFF_CTRL, 32'h08);
      `CHK(host_role_enable, 1'b1)
      `CHK(module_enable, 1'b0)
      far.set_token(1'b1);
      rchk(usb_regs_pkg::OFF_CTRL, 32'ha8);
      far.set_token(1'b0);
      rchk(usb_regs_pkg::OFF_CTRL, 32'h88);
      wr(usb_regs_pkg::OFF_CTRL, 32'h18);
      `CHK(bus_reset_drive, 1'b1)
      wr(usb_regs_pkg::OFF_CTRL, 32'h0c);
      `CHK(bus_reset_drive, 1'b0)
      `CHK(resume_drive, 1'b1)
      // Resume hold is far shorter than the wake-up time to keep the run short
      repeat (20) @(posedge core_clk);
      wr(usb_regs_pkg::OFF_CTRL, 32'h08);
      `CHK(resume_drive, 1'b0)
      repeat (usb_regs_pkg::EOP_CYCLES + 10) @(posedge core_clk);
      `CHK(n_eop, usb_regs_pkg::EOP_CYCLES)
      wr(usb_regs_pkg::OFF_CTRL, 32'h0a);
      `CHK(pingpong_pointer_clear, 1'b1)
      `CHK(n_sof, 0)
      // One frame of SOF: the first strobe comes one full frame after enable
      wr(usb_regs_pkg::OFF_CTRL, 32'h09);
      repeat (usb_regs_pkg::FRAME_CYCLES + 4) @(posedge core_clk);
      `CHK(n_sof, 1)
      wr(usb_regs_pkg::OFF_CTRL, 32'h00);
      repeat (4) @(posedge core_clk);
      `CHK(n_hrst, 2)
      `CHK(host_role_enable, 1'b0)
      test_done();
   end
endmodule

// ### usb_error_status_control_regs.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// How it works
// - Eight error enable bits each pass or block their matching error flag.
// - Enable bit 1 gates token check error as peripheral, frame end error as host.
// - Gated errors reach module interrupt only with error master enable set.
// - Bits 31 to 8 of all four registers read as zero.
// - Status bits 7 to 4 show oldest pending transfer's endpoint number.
// - Status bit 3 is 1 for transmit, 0 for receive.
// - Status bit 2 is 1 for odd bank, 0 for even.
// - Status bits 1 and 0 read as zero.
// - Status shows head of four-entry queue; clearing done flag pops it.
// - Control bit 7 live-reflects J state on the bus.
// - Control bit 6 live-reflects single-ended zero on the bus.
// - Peripheral: bit 5 set on SETUP token, holds processing until cleared.
// - Host: bit 5 reads 1 while a token executes.
// - Host: bit 4 drives bus reset while set.
// - Bit 3 enables host role; every toggle resets host logic.
// - Host: clearing resume appends a low-speed end-of-packet.
// - Setting bit 1 resets all ping-pong pointers to even bank.
// - Peripheral: bit 0 enables the module and its circuitry.
// - Host: bit 0 sends a start-of-frame token every millisecond.
module usb_error_status_control_regs
(
   input  wire logic                     core_clk,
   input  wire logic                     arst_n,
   input  usb_regs_pkg::bus_req_s        bus_req,
   output logic [31:0]                   rdata,
   input  wire logic [7:0]               err_flags,
   input  wire logic                     err_irq_master_en,
   output logic                          err_irq,
   output logic                          module_irq_req,
   input  wire logic                     xfer_done,
   input  usb_regs_pkg::xfer_rec_s       xfer_rec,
   output logic                          xfer_ready,
   output logic                          transaction_done_flag,
   input  wire logic                     setup_token_seen,
   input  wire logic                     token_active,
   input  wire logic                     dp_pin,
   input  wire logic                     dm_pin,
   output logic                          token_hold,
   output logic                          bus_reset_drive,
   output logic                          host_role_enable,
   output logic                          host_logic_reset,
   output logic                          resume_drive,
   output logic                          ls_eop_drive,
   output logic                          pingpong_pointer_clear,
   output logic                          module_enable,
   output logic                          sof_strobe
);
   // -------------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------------
   logic [7:0]  err_en_q;
   logic        hold_q;
   logic        busrst_q;
   logic        host_q;
   logic        resume_q;
   logic        ppclr_q;
   logic        en_q;
   logic        hostrst_q;
   logic        eop_run_q;
   logic [15:0] eop_cnt_q;
   logic [23:0] sof_cnt_q;
   logic [31:0] rdata_q;

   // -------------------------------------------------------------------------
   // Line levels and decode
   // -------------------------------------------------------------------------
   logic dp_s;
   logic dm_s;

   usb_line_sync u_dp_sync (.core_clk(core_clk), .arst_n(arst_n), .pin(dp_pin), .level(dp_s));
   usb_line_sync u_dm_sync (.core_clk(core_clk), .arst_n(arst_n), .pin(dm_pin), .level(dm_s));

   // Full-speed J is D+ high; SE0 is both lines low
   wire live_j_level = dp_s && !dm_s;
   wire live_se0     = !dp_s && !dm_s;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   wire wr_en_reg   = bus_req.wr && hit(bus_req.addr, usb_regs_pkg::OFF_ERR_EN);
   wire wr_ctrl     = bus_req.wr && hit(bus_req.addr, usb_regs_pkg::OFF_CTRL);
   wire wr_misc     = bus_req.wr && hit(bus_req.addr, usb_regs_pkg::OFF_MISC);
   wire [7:0] wbyte = bus_req.wdata[7:0];

   // -------------------------------------------------------------------------
   // Error interrupt gating
   // -------------------------------------------------------------------------
   // Flag inputs are already role-muxed on bit 1, so one enable serves both roles
   assign err_irq        = |(err_flags & err_en_q);
   assign module_irq_req = err_irq && err_irq_master_en;

   // -------------------------------------------------------------------------
   // Status queue
   // -------------------------------------------------------------------------
   usb_regs_pkg::xfer_rec_s head;
   logic fifo_full;
   logic fifo_ne;
   wire  pop = wr_misc && wbyte[usb_regs_pkg::MISC_DONE] && fifo_ne;

   // A full queue stalls the engine rather than dropping a record
   assign xfer_ready            = !fifo_full;
   assign transaction_done_flag = fifo_ne;

   usb_status_fifo u_fifo
   (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .push      (xfer_done && xfer_ready),
      .push_rec  (xfer_rec),
      .pop       (pop),
      .head      (head),
      .not_empty (fifo_ne),
      .full      (fifo_full)
   );

   // Record view only while a record is pending; an empty queue reads zero
   wire [7:0] status_byte = fifo_ne ? {head.endpoint, head.tx, head.odd, 2'b00}
                                    : usb_regs_pkg::BYTE_ZERO;

   // -------------------------------------------------------------------------
   // Control byte view
   // -------------------------------------------------------------------------
   wire bit5_view = host_q ? token_active : hold_q;
   wire [7:0] ctrl_byte = {live_j_level, live_se0, bit5_view, busrst_q,
                           host_q, resume_q, ppclr_q, en_q};

   // Outputs; host-only functions are gated on the role
   assign token_hold             = hold_q && !host_q;
   assign bus_reset_drive        = busrst_q && host_q && !hostrst_q;
   assign host_role_enable       = host_q;
   assign host_logic_reset       = hostrst_q;
   assign resume_drive           = resume_q;
   assign ls_eop_drive           = eop_run_q;
   assign pingpong_pointer_clear = ppclr_q;
   assign module_enable          = en_q && !host_q;
   assign sof_strobe             = host_q && en_q && !hostrst_q &&
                                   (sof_cnt_q == 24'(usb_regs_pkg::FRAME_CYCLES - 1));

   // -------------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------------
   // Hold bit: a SETUP arriving in the clearing cycle wins over the clear
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         hold_q <= 1'b0;
      else if (setup_token_seen && !host_q)
         hold_q <= 1'b1;
      else if (wr_ctrl && !host_q)
         hold_q <= wbyte[usb_regs_pkg::CTL_HOLD];
   end

   // Plain writable control bits
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         err_en_q <= 8'h00;
         busrst_q <= 1'b0;
         host_q   <= 1'b0;
         resume_q <= 1'b0;
         ppclr_q  <= 1'b0;
         en_q     <= 1'b0;
      end
      else
      begin
         if (wr_en_reg)
            err_en_q <= wbyte;
         if (wr_ctrl)
         begin
            busrst_q <= wbyte[usb_regs_pkg::CTL_BUSRST];
            host_q   <= wbyte[usb_regs_pkg::CTL_HOST];
            resume_q <= wbyte[usb_regs_pkg::CTL_RESUME];
            ppclr_q  <= wbyte[usb_regs_pkg::CTL_PPCLR];
            en_q     <= wbyte[usb_regs_pkg::CTL_EN];
         end
      end
   end

   // Host logic reset: one-cycle pulse in the same cycle as any change of the role bit
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         hostrst_q <= 1'b0;
      else
         hostrst_q <= wr_ctrl && (wbyte[usb_regs_pkg::CTL_HOST] != host_q);
   end

   // -------------------------------------------------------------------------
   // Resume end-of-packet and frame timer
   // -------------------------------------------------------------------------
   // Falling edge of resume in host role starts a fixed-length low-speed EOP
   // A clear that also leaves the host role sends no EOP, as host logic resets anyway
   wire resume_fall = wr_ctrl && resume_q && !wbyte[usb_regs_pkg::CTL_RESUME] &&
                      host_q && wbyte[usb_regs_pkg::CTL_HOST];

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         eop_run_q <= 1'b0;
         eop_cnt_q <= 16'h0000;
      end
      else if (resume_fall)
      begin
         eop_run_q <= 1'b1;
         eop_cnt_q <= 16'(usb_regs_pkg::EOP_CYCLES - 1);
      end
      else if (hostrst_q)
      begin
         eop_run_q <= 1'b0;
         eop_cnt_q <= 16'h0000;
      end
      else if (eop_run_q)
      begin
         eop_run_q <= (eop_cnt_q != 16'h0000);
         eop_cnt_q <= eop_cnt_q - 16'h0001;
      end
   end

   // Frame counter restarts when the host role resets, so the first SOF is a full frame late
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         sof_cnt_q <= 24'h000000;
      else if (hostrst_q || !(host_q && en_q) || sof_strobe)
         sof_cnt_q <= 24'h000000;
      else
         sof_cnt_q <= sof_cnt_q + 24'h000001;
   end

   // -------------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------------
   wire [7:0] rd_byte =
      hit(bus_req.addr, usb_regs_pkg::OFF_ERR_EN) ? err_en_q :
      hit(bus_req.addr, usb_regs_pkg::OFF_STATUS) ? status_byte :
      hit(bus_req.addr, usb_regs_pkg::OFF_CTRL)   ? ctrl_byte :
      hit(bus_req.addr, usb_regs_pkg::OFF_MISC)   ? {6'h00, err_irq_master_en, fifo_ne} :
      usb_regs_pkg::BYTE_ZERO;

   // Data only in the cycle after the read strobe, zero elsewhere
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_q <= 32'h00000000;
      else if (bus_req.rd)
         rdata_q <= {usb_regs_pkg::PAD_ZERO, rd_byte};
      else
         rdata_q <= 32'h00000000;
   end
   assign rdata = rdata_q;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   a_irq_master_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
      module_irq_req |-> (err_irq_master_en && |(err_flags & err_en_q)))
      else $error("Module interrupt without master enable");
   a_upper_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
      rdata[31:8] == 24'h000000)
      else $error("Upper read bits not zero");
   a_status_low_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
      $past(bus_req.rd) && $past(bus_req.addr) == usb_regs_pkg::OFF_STATUS |-> rdata[1:0] == 2'b00)
      else $error("Status low bits not zero");
   a_setup_sets_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
      setup_token_seen && !host_q |=> hold_q)
      else $error("SETUP did not set hold");
   a_full_stalls: assert property (@(posedge core_clk) disable iff (!arst_n)
      fifo_full |-> !xfer_ready)
      else $error("Full queue accepted a record");
   a_role_toggle_rst: assert property (@(posedge core_clk) disable iff (!arst_n)
      host_q != $past(host_q) |-> hostrst_q)
      else $error("Role change without host reset");
   a_eop_after_resume: assert property (@(posedge core_clk) disable iff (!arst_n)
      resume_fall |=> eop_run_q [*2])
      else $error("No EOP after resume clear");
   a_pop_advances: assert property (@(posedge core_clk) disable iff (!arst_n)
      pop && !(xfer_done && xfer_ready) |=> $past(u_fifo.cnt_q) == u_fifo.cnt_q + 3'h1)
      else $error("Pop did not advance the queue");
   a_sof_period: assert property (@(posedge core_clk) disable iff (!arst_n)
      sof_strobe |=> !sof_strobe [*8])
      else $error("Start-of-frame too soon");
   a_hold_until_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
      hold_q && !(wr_ctrl && !host_q) |=> hold_q)
      else $error("Hold bit dropped without a clear");
   a_empty_status_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
      $past(bus_req.rd) && $past(bus_req.addr) == usb_regs_pkg::OFF_STATUS &&
      !$past(fifo_ne) |-> rdata == 32'h00000000)
      else $error("Empty queue status not zero");
   a_ready_after_pop: assert property (@(posedge core_clk) disable iff (!arst_n)
      fifo_full && pop |=> xfer_ready)
      else $error("Queue stayed full after a pop");
   a_eop_clean_end: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(eop_run_q) && !$past(hostrst_q) |-> $past(eop_cnt_q) == 16'h0000)
      else $error("EOP ended early");
   a_sof_full_frame: assert property (@(posedge core_clk) disable iff (!arst_n)
      sof_strobe |-> $past(sof_cnt_q) == 24'(usb_regs_pkg::FRAME_CYCLES - 2))
      else $error("Start-of-frame before a full frame");
endmodule

// ### usb_far_side_model.sv
`timescale 1ns/10ps
// Far-side stand-in: bus line levels, token activity and completed transfers
module usb_far_side_model
(
   input  wire logic               core_clk,
   input  wire logic               xfer_ready,
   output logic                    xfer_done,
   output usb_regs_pkg::xfer_rec_s xfer_rec,
   output logic                    setup_token_seen,
   output logic                    token_active,
   output logic                    dp_pin,
   output logic                    dm_pin
);
   // -------------------------------------------------------------------------
   // Idle state
   // -------------------------------------------------------------------------
   // Bus idles in J so the live line flags have a known start
   initial
   begin
      xfer_done        = 1'b0;
      xfer_rec         = '0;
      setup_token_seen = 1'b0;
      token_active     = 1'b0;
      dp_pin           = 1'b1;
      dm_pin           = 1'b0;
   end

   // -------------------------------------------------------------------------
   // Actions
   // -------------------------------------------------------------------------
   // Lines are asynchronous to the core, so they change off the edge
   task automatic set_line(input logic dp, input logic dm);
      #3;
      dp_pin = dp;
      dm_pin = dm;
   endtask

   // Completion is offered until the queue has room; a full queue stalls it
   task automatic complete(input usb_regs_pkg::xfer_rec_s r);
      #1;
      xfer_done <= 1'b1;
      xfer_rec  <= r;
      @(posedge core_clk);
      while (xfer_ready !== 1'b1)
      begin
         @(posedge core_clk);
      end
      xfer_done <= 1'b0;
      xfer_rec  <= ~r;   // No stale record left on the lines
   endtask

   task automatic setup_pulse();
      #1;
      setup_token_seen <= 1'b1;
      @(posedge core_clk);
      setup_token_seen <= 1'b0;
   endtask

   task automatic set_token(input logic busy);
      #1;
      token_active <= busy;
   endtask
endmodule

// ### usb_line_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; the output moves only when stages two and three agree
module usb_line_sync
(
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic pin,
   output logic      level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            level <= s3_q;
      end
   end
endmodule

// ### usb_regs_pkg.sv
package usb_regs_pkg;

   // -------------------------------------------------------------------------
   // Register map and field positions
   // -------------------------------------------------------------------------
   localparam logic [7:0] OFF_ERR_EN = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CTRL   = 8'h08;
   localparam logic [7:0] OFF_MISC   = 8'h0c;

   localparam int CTL_J      = 7;
   localparam int CTL_SE0    = 6;
   localparam int CTL_HOLD   = 5;
   localparam int CTL_BUSRST = 4;
   localparam int CTL_HOST   = 3;
   localparam int CTL_RESUME = 2;
   localparam int CTL_PPCLR  = 1;
   localparam int CTL_EN     = 0;

   localparam int ERR_FRAME_BIT = 1;
   localparam int FIFO_DEPTH    = 4;
   localparam int MISC_DONE     = 0;
   localparam int MISC_ERRIE    = 1;

   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [23:0] PAD_ZERO  = 24'h000000;

   // -------------------------------------------------------------------------
   // Frame timing
   // -------------------------------------------------------------------------
   localparam int CLK_MHZ      = 100;
   localparam int FRAME_US     = 1000;
   localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
   localparam int LS_EOP_NS    = 1330;
   localparam int EOP_CYCLES   = (LS_EOP_NS * CLK_MHZ + 999) / 1000;

   // One completed-transaction record
   typedef struct packed {
      logic [3:0] endpoint;
      logic       tx;
      logic       odd;
   } xfer_rec_s;

   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_s;

endpackage

// ### usb_status_fifo.sv
`timescale 1ns/10ps
// Four-deep queue of transfer records; head is always visible
module usb_status_fifo
(
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic                  push,
   input  usb_regs_pkg::xfer_rec_s    push_rec,
   input  wire logic                  pop,
   output usb_regs_pkg::xfer_rec_s    head,
   output logic                       not_empty,
   output logic                       full
);
   usb_regs_pkg::xfer_rec_s mem_q [usb_regs_pkg::FIFO_DEPTH];
   logic [1:0] wp_q;
   logic [1:0] rp_q;
   logic [2:0] cnt_q;
   wire        do_push = push && !full;
   wire        do_pop  = pop && not_empty;

   assign not_empty = (cnt_q != 3'h0);
   assign full      = (cnt_q == 3'(usb_regs_pkg::FIFO_DEPTH));
   assign head      = mem_q[rp_q];

   // Pointers and count; a push into a full queue never happens upstream
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wp_q  <= 2'h0;
         rp_q  <= 2'h0;
         cnt_q <= 3'h0;
      end
      else
      begin
         wp_q  <= wp_q + 2'(do_push);
         rp_q  <= rp_q + 2'(do_pop);
         cnt_q <= cnt_q + 3'(do_push) - 3'(do_pop);
      end
   end

   // Storage has no reset; it reads only behind a valid count
   always_ff @(posedge core_clk)
   begin
      if (do_push)
         mem_q[wp_q] <= push_rec;
   end
endmodule
